//--- dacsd_core.sv
// Serial shift path, output phase, command apply and converter codes
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Serial output driven from last shift register stage in mode 0, from the next-to-last stage in mode 1.
// - Mode 0 changes output on falling edge, mode 1 on rising.
// - Mode 0 lag from input to output is 12.5 clock cycles.
// - Mode 1 lag from input to output is exactly 12 cycles.
// - Mode 0 selected after reset until a phase command.
// - Serial output always driven high or low, never floating.
// - Serial output held unchanged while chip select high.
// - Devices chain output to input sharing clock and select.
// - No-operation word only shifts through, registers untouched.
// - Words act together on chip select rising edge.
// - Shared load strobe updates several devices together.
// - Code is straight unsigned binary, output code times ref over 256.
// - Each device takes one 12-bit word: address, control, data.
// - No-operation is zero address and control, data ignored.
// - Rising phase command sets mode 1 and loads all converters.
// - Falling phase command sets mode 0 and loads all converters.
module dacsd_core (
   input  wire logic                                              clk,
   input  wire logic                                              rst,
   input  wire logic                                              sclk,
   input  wire logic                                              cs_n,
   input  wire logic                                              din,
   input  wire logic                                              load_strobe_n,
   output logic                                                   dout,
   output logic                                                   dout_oe,
   output logic                                                   phase_mode,
   output logic [dacsd_pkg::NUM_CH-1:0][dacsd_pkg::CODE_BITS-1:0] code_value,
   output logic [dacsd_pkg::WORD_BITS-1:0]                        word_data,
   output logic                                                   word_valid,
   input  wire logic                                              word_ready
);
   import dacsd_pkg::*;

   // Three stage synchronisers; stage one feeds stage two only
   logic [2:0] sclk_s;
   logic [2:0] cs_s;
   logic [2:0] din_s;
   logic [2:0] ld_s;
   logic       sclk_q;
   logic       cs_q;
   logic       din_q;
   logic       ld_q;
   logic       sclk_prev;
   logic       cs_prev;

   function automatic logic settle(input logic [2:0] s, input logic q);
      return (s[1] == s[2]) ? s[2] : q;
   endfunction

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sclk_s <= 3'h0;
         cs_s   <= 3'h7;
         din_s  <= 3'h0;
         ld_s   <= 3'h7;
      end else begin
         sclk_s <= {sclk_s[1:0], sclk};
         cs_s   <= {cs_s[1:0], cs_n};
         din_s  <= {din_s[1:0], din};
         ld_s   <= {ld_s[1:0], load_strobe_n};
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sclk_q    <= 1'b0;
         cs_q      <= 1'b1;
         din_q     <= 1'b0;
         ld_q      <= 1'b1;
         sclk_prev <= 1'b0;
         cs_prev   <= 1'b1;
      end else begin
         sclk_q    <= settle(sclk_s, sclk_q);
         cs_q      <= settle(cs_s, cs_q);
         din_q     <= settle(din_s, din_q);
         ld_q      <= settle(ld_s, ld_q);
         sclk_prev <= sclk_q;
         cs_prev   <= cs_q;
      end
   end

   logic sclk_rise;
   logic sclk_fall;
   logic cs_rise;
   assign sclk_rise = sclk_q && !sclk_prev && !cs_q;
   assign sclk_fall = !sclk_q && sclk_prev && !cs_q;
   assign cs_rise   = cs_q && !cs_prev;

   ////////////////////////////////////////////////////////////////////////////
   // Shift register and output stage
   logic [WORD_BITS-1:0] shreg;
   logic                 mode;
   logic                 out_bit;
   dacsd_frame_type      frame;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         shreg <= '0;
      end else if (sclk_rise) begin
         shreg <= {shreg[WORD_BITS-2:0], din_q};
      end
   end

   // Mode 0 re-times the last stage half a clock later
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         out_bit <= 1'b0;
      end else if (!mode && sclk_fall) begin
         out_bit <= shreg[WORD_BITS-1];
      end else if (mode && sclk_rise) begin
         out_bit <= shreg[WORD_BITS-2];
      end
   end

   assign dout       = out_bit;
   assign dout_oe    = 1'b1;
   assign phase_mode = mode;

   // Commit needs a seen low phase, so select noise at reset commits nothing
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         frame <= DACSD_IDLE;
      end else begin
         case (frame)
            DACSD_IDLE: begin
               if (!cs_q) begin
                  frame <= DACSD_SHIFT;
               end
            end
            DACSD_SHIFT: begin
               if (cs_q) begin
                  frame <= DACSD_END;
               end
            end
            DACSD_END: begin
               frame <= DACSD_IDLE;
            end
            default: begin
               frame <= DACSD_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Committed words queue up before being applied
   logic [WORD_BITS-1:0] q_data;
   logic                 q_valid;
   logic                 q_ready;
   logic                 fifo_in_ready;
   logic                 commit;
   // A cut frame still commits the register as it stands; the host owns framing
   assign commit = cs_rise && (frame == DACSD_SHIFT);

   dacsd_fifo #(
      .W (FIFO_W),
      .D (FIFO_D)
   ) u_fifo (
      .clk       (clk),
      .rst       (rst),
      .in_data   (shreg),
      .in_valid  (commit),
      .in_ready  (fifo_in_ready),
      .out_data  (q_data),
      .out_valid (q_valid),
      .out_ready (q_ready)
   );

   // Apply stalls while the word port is back-pressured
   assign q_ready    = word_ready;
   assign word_valid = q_valid;
   assign word_data  = q_data;

   logic [3:0]           cmd;
   logic [1:0]           addr;
   logic [CODE_BITS-1:0] data;
   logic                 apply;
   assign cmd   = q_data[ADDR_HI:CTRL_LO];
   assign addr  = q_data[ADDR_HI:ADDR_LO];
   assign data  = q_data[CODE_BITS-1:0];
   assign apply = q_valid && q_ready;

   // Phase survives everything but reset and the two phase commands
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mode <= 1'b0;
      end else if (apply && cmd == CMD_PH_RISE) begin
         mode <= 1'b1;
      end else if (apply && cmd == CMD_PH_FALL) begin
         mode <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Input and converter registers, straight binary codes
   logic [NUM_CH-1:0][CODE_BITS-1:0] in_reg;
   logic [NUM_CH-1:0][CODE_BITS-1:0] dac_reg;
   logic                             is_load;
   logic                             xfer_all;
   assign is_load  = (q_data[CTRL_HI:CTRL_LO] == CTRL_LOAD)
                  || (q_data[CTRL_HI:CTRL_LO] == CTRL_LOAD_UP);
   assign xfer_all = apply && (cmd == CMD_SW_LOAD || cmd == CMD_PH_RISE
                  || cmd == CMD_PH_FALL);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         in_reg <= '0;
      end else if (apply && is_load) begin
         in_reg[addr] <= data;
      end
   end

   // Load strobe low makes converters transparent to the input registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dac_reg <= '0;
      end else if (apply && cmd == CMD_LOAD_ALL) begin
         for (int i = 0; i < NUM_CH; i++) begin
            dac_reg[i] <= data;
         end
      end else if (!ld_q || xfer_all
                   || (apply && q_data[CTRL_HI:CTRL_LO] == CTRL_LOAD_UP)) begin
         dac_reg <= in_reg;
         if (apply && is_load) begin
            dac_reg[addr] <= data;
         end
      end
   end

   assign code_value = dac_reg;

   ////////////////////////////////////////////////////////////////////////////
   a_idle_hold: assert property (@(posedge clk) disable iff (rst)
      cs_q && cs_prev |-> $stable(dout))
      else $error("serial output moved while deselected");
   a_drive_on: assert property (@(posedge clk) disable iff (rst)
      dout_oe == 1'b1)
      else $error("serial output released");
   a_fall_mode: assert property (@(posedge clk) disable iff (rst)
      !mode && sclk_fall |=> dout == $past(shreg[WORD_BITS-1]))
      else $error("mode 0 output not last stage");
   a_rise_mode: assert property (@(posedge clk) disable iff (rst)
      mode && sclk_rise |=> dout == $past(shreg[WORD_BITS-2]))
      else $error("mode 1 output wrong stage");
   a_shift_in: assert property (@(posedge clk) disable iff (rst)
      sclk_rise |=> shreg[0] == $past(din_q))
      else $error("input not sampled on rising edge");
   a_nop_keep: assert property (@(posedge clk) disable iff (rst)
      apply && cmd == CMD_NOP && ld_q |=> $stable(in_reg) && $stable(dac_reg))
      else $error("no-operation changed registers");
   a_phase_set: assert property (@(posedge clk) disable iff (rst)
      apply && cmd == CMD_PH_RISE |=> mode ##0 dac_reg == $past(in_reg))
      else $error("rising phase command failed");
   a_phase_clr: assert property (@(posedge clk) disable iff (rst)
      apply && cmd == CMD_PH_FALL |=> !mode)
      else $error("falling phase command failed");
   a_commit_word: assert property (@(posedge clk) disable iff (rst)
      commit && fifo_in_ready |=> q_valid)
      else $error("committed word lost");
   a_code_out: assert property (@(posedge clk) disable iff (rst)
      apply && cmd == CMD_LOAD_ALL |=> code_value == {NUM_CH{$past(data)}})
      else $error("converters not loaded with the shifted code");

   // Each phase keeps still on the edge it does not own
   a_rise_quiet: assert property (@(posedge clk) disable iff (rst)
      !mode && sclk_rise |=> $stable(dout))
      else $error("mode 0 output moved on a rising edge");
   a_fall_quiet: assert property (@(posedge clk) disable iff (rst)
      mode && sclk_fall |=> $stable(dout))
      else $error("mode 1 output moved on a falling edge");
   a_mode_keep: assert property (@(posedge clk) disable iff (rst)
      !(apply && (cmd == CMD_PH_RISE || cmd == CMD_PH_FALL)) |=> $stable(mode))
      else $error("phase changed without a phase command");
   a_shift_hold: assert property (@(posedge clk) disable iff (rst)
      cs_q |=> $stable(shreg))
      else $error("shift register moved while deselected");

   // Register loads from commands and from the strobe pin
   a_load_input: assert property (@(posedge clk) disable iff (rst)
      apply && is_load |=> in_reg[$past(addr)] == $past(data))
      else $error("input register not loaded");
   a_load_pass: assert property (@(posedge clk) disable iff (rst)
      !ld_q && !apply |=> dac_reg == $past(in_reg))
      else $error("converters not following inputs under strobe");
   a_sw_load: assert property (@(posedge clk) disable iff (rst)
      apply && cmd == CMD_SW_LOAD |=> dac_reg == $past(in_reg))
      else $error("software load did not copy inputs");
   a_phase_load: assert property (@(posedge clk) disable iff (rst)
      apply && cmd == CMD_PH_FALL |=> dac_reg == $past(in_reg))
      else $error("falling phase command did not load converters");

   // Stalled head must hold until taken
   a_word_hold: assert property (@(posedge clk) disable iff (rst)
      word_valid && !word_ready |=> word_valid && $stable(word_data))
      else $error("queued word changed while stalled");
endmodule

//--- dacsd_fifo.sv
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ns
module dacsd_fifo #(
   parameter int W = 12,
   parameter int D = 16
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] in_data,
   input  wire logic         in_valid,
   output logic              in_ready,
   output logic [W-1:0]      out_data,
   output logic              out_valid,
   input  wire logic         out_ready
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem [D];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0]   count;
   logic          push;
   logic          pop;
   assign in_ready  = (count != (AW+1)'(D));
   assign out_valid = (count != '0);
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign out_data  = mem[rd_ptr];
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
         count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

//--- dacsd_host.sv
// Serial host model for the shift interface and daisy-chain output
`timescale 1ns/1ns
module dacsd_host (
   output logic      sclk,
   output logic      cs_n,
   output logic      din,
   input  wire logic dout
);
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      din  = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Frame of n bits, MSB first; din moves as select goes low, after each falling edge and at release
   task automatic xfer(input int n, input logic [23:0] bits, output logic [23:0] seen);
      seen = '0;
      cs_n = 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         din = bits[i];
         #400 sclk = 1'b1;
         #390 seen[i] = dout;
         #10 sclk = 1'b0;
      end
      #400 cs_n = 1'b1;
      // Released data line must not keep the last bit
      din = ~din;
      #800;
   endtask

   // Stray pulses with select high, which the device must ignore
   task automatic stray(input int n);
      repeat (n) begin
         #400 sclk = 1'b1;
         #400 sclk = 1'b0;
      end
   endtask
endmodule

//--- dacsd_pkg.sv
// Constants and types for the DAC serial output and daisy-chain block
package dacsd_pkg;
   localparam int WORD_BITS = 12;
   localparam int CODE_BITS = 8;
   localparam int NUM_CH    = 4;
   localparam int ADDR_HI   = 11;
   localparam int ADDR_LO   = 10;
   localparam int CTRL_HI   = 9;
   localparam int CTRL_LO   = 8;
   localparam int FIFO_W    = 12;
   localparam int FIFO_D    = 16;
   localparam logic [3:0] CMD_NOP      = 4'h0;
   localparam logic [3:0] CMD_UPO_LO   = 4'h2;
   localparam logic [3:0] CMD_SW_LOAD  = 4'h4;
   localparam logic [3:0] CMD_UPO_HI   = 4'h6;
   localparam logic [3:0] CMD_LOAD_ALL = 4'h8;
   localparam logic [3:0] CMD_PH_FALL  = 4'ha;
   localparam logic [3:0] CMD_SHUTDOWN = 4'hc;
   localparam logic [3:0] CMD_PH_RISE  = 4'he;
   localparam logic [1:0] CTRL_LOAD    = 2'h1;
   localparam logic [1:0] CTRL_LOAD_UP = 2'h3;
   localparam logic [7:0] CODE_ZERO    = 8'h00;
   typedef enum logic [1:0] {
      DACSD_IDLE  = 2'b00,
      DACSD_SHIFT = 2'b01,
      DACSD_END   = 2'b11
   } dacsd_frame_type;
endpackage

//--- dacsd_tb_top.sv
// Self-checking bench for the serial output, phase and FIFO path
`timescale 1ns/1ns
module dacsd_tb_top;
   import dacsd_pkg::*;
   logic                                clk;
   logic                                rst;
   logic                                sclk;
   logic                                cs_n;
   logic                                din;
   logic                                load_strobe_n;
   logic                                dout;
   logic                                dout_oe;
   logic                                phase_mode;
   logic [NUM_CH-1:0][CODE_BITS-1:0]    code_value;
   logic [WORD_BITS-1:0]                word_data;
   logic                                word_valid;
   logic                                word_ready;
   logic [23:0]                         seen;
   int                                  err_count = 0;
   int                                  n_compared = 0;

   dacsd_core u_dut (
      .clk(clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .din(din),
      .load_strobe_n(load_strobe_n), .dout(dout), .dout_oe(dout_oe),
      .phase_mode(phase_mode), .code_value(code_value), .word_data(word_data),
      .word_valid(word_valid), .word_ready(word_ready)
   );
   dacsd_host u_host (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk_bit(string what, logic exp, logic got);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chk_val(string what, logic [11:0] exp, logic [11:0] got);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask

   // Frames start just off a clock edge so no pin moves on one
   task automatic frame(int n, logic [23:0] bits);
      @(posedge clk);
      #1 u_host.xfer(n, bits, seen);
   endtask

   // One word frame, then time for commit and apply
   task automatic send(logic [11:0] w);
      frame(12, {12'h000, w});
      repeat (10) @(posedge clk);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      chk_bit("phase_mode", 1'b0, phase_mode);
      chk_bit("dout_oe", 1'b1, dout_oe);
      chk_val("code_a", 12'h000, {4'h0, code_value[0]});
      $display("test reset done");
   endtask

   task automatic t_cmds;
      send(12'h7a5);
      chk_val("code_b", 12'h0a5, {4'h0, code_value[1]});
      send(12'h93c);
      chk_val("code_c", 12'h000, {4'h0, code_value[2]});
      send(12'h0ff);
      chk_val("code_b", 12'h0a5, {4'h0, code_value[1]});
      send({CMD_PH_RISE, 8'h00});
      chk_bit("phase_mode", 1'b1, phase_mode);
      chk_val("code_c", 12'h03c, {4'h0, code_value[2]});
      $display("test commands done");
   endtask

   // Frame of 24 bits; the second word is a no-op so nothing else moves
   task automatic t_lag(int lag);
      logic [23:0] bits;
      logic        held;
      bits = {12'hb4d, 12'h0e7};
      frame(24, bits);
      for (int k = 0; k + lag < 24; k++) begin
         chk_bit("dout", bits[k + lag], seen[k]);
      end
      held = dout;
      u_host.stray(3);
      repeat (10) @(posedge clk);
      chk_bit("dout held", held, dout);
      chk_bit("word_valid", 1'b0, word_valid);
      $display("test lag %0d done", lag);
   endtask

   task automatic t_loads;
      @(posedge clk);
      #1 load_strobe_n = 1'b0;
      send(12'hd77);
      chk_val("code_d", 12'h077, {4'h0, code_value[3]});
      #1 load_strobe_n = 1'b1;
      send({CMD_LOAD_ALL, 8'h00});
      for (int c = 0; c < NUM_CH; c++) begin
         chk_val("code", 12'h000, {4'h0, code_value[c]});
      end
      send({CMD_SW_LOAD, 8'h00});
      chk_val("code_d", 12'h077, {4'h0, code_value[3]});
      $display("test loads done");
   endtask

   // Seventeen no-op words against a stalled drain; the last is dropped
   task automatic t_fifo;
      @(posedge clk);
      #1 word_ready = 1'b0;
      for (int i = 0; i < FIFO_D + 1; i++) begin
         frame(12, {12'h000, 4'h0, i[7:0]});
      end
      repeat (10) @(posedge clk);
      for (int i = 0; i < FIFO_D; i++) begin
         chk_bit("word_valid", 1'b1, word_valid);
         chk_val("word_data", {4'h0, i[7:0]}, word_data);
         @(posedge clk);
         #1 word_ready = 1'b1;
         @(posedge clk);
         #1 word_ready = 1'b0;
         @(posedge clk);
      end
      chk_bit("word_valid", 1'b0, word_valid);
      #1 word_ready = 1'b1;
      $display("test fifo done");
   endtask

   task automatic stop_test;
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      rst = 1'b1;
      load_strobe_n = 1'b1;
      word_ready = 1'b1;
      repeat (2) @(posedge clk);
      #1 rst = 1'b0;
      repeat (5) @(posedge clk);
      t_reset;
      t_cmds;
      t_lag(12);
      send({CMD_PH_FALL, 8'h00});
      chk_bit("phase_mode", 1'b0, phase_mode);
      t_lag(12);
      t_loads;
      t_fifo;
      stop_test;
   end

   // About 3000 cycles expected; cut off far beyond that
   initial begin
      #2000000;
      err_count++;
      $display("watchdog expired");
      stop_test;
   end
endmodule
